// [inc/rsar_pkg.sv]
package rsar_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the command port
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CHANNEL = 5'h05;
    localparam logic [4:0] ADDR_STATUS = 5'h07;
    localparam logic [4:0] ADDR_OBSERVE = 5'h08;
    localparam logic [4:0] ADDR_POWER = 5'h09;
    localparam logic [4:0] ADDR_PIPE0 = 5'h0a;
    localparam logic [4:0] ADDR_PIPE1 = 5'h0b;
    localparam logic [4:0] ADDR_PIPE2 = 5'h0c;
    localparam logic [4:0] ADDR_PIPE3 = 5'h0d;

    // ----------------------------------------------------------------
    // Command byte: top three bits select the operation
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_RX_READY = 6;
    localparam int BIT_TX_DONE = 5;
    localparam int BIT_RETRY = 4;
    localparam int BIT_TX_FULL = 0;
    localparam int PIPE_LSB = 1;
    localparam int LOST_LSB = 4;
    localparam int RETX_LSB = 0;
    localparam int ADDR_BYTES_MAX = 5;
    localparam int CNT_WIDTH = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] PIPE_EMPTY = 3'h7;
    localparam logic [39:0] PIPE0_RESET = 40'he7e7e7e7e7;
    localparam logic [39:0] PIPE1_RESET = 40'hc2c2c2c2c2;
    localparam logic [7:0] PIPE2_RESET = 8'hc3;
    localparam logic [7:0] PIPE3_RESET = 8'hc4;

    // ----------------------------------------------------------------
    // Address width codes
    // ----------------------------------------------------------------
    localparam logic [1:0] AW_ILLEGAL = 2'h0;
    localparam logic [1:0] AW_3 = 2'h1;
    localparam logic [1:0] AW_4 = 2'h2;
    localparam logic [1:0] AW_5 = 2'h3;

    typedef enum logic [1:0] {
        RSAR_IDLE = 2'b00,
        RSAR_CMD = 2'b01,
        RSAR_DATA = 2'b11
    } rsar_phase_t;

endpackage

// [inc/rsar_spi_if.sv]
interface rsar_spi_if;
    logic frame_start;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    modport shifter (
        output frame_start,
        output rx_valid,
        output rx_byte,
        input tx_byte
    );
    modport core (
        input frame_start,
        input rx_valid,
        input rx_byte,
        output tx_byte
    );
endinterface

// [src/rsar_spi_shifter.sv]
module rsar_spi_shifter (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    rsar_spi_if.shifter bus
);
    typedef struct packed {
        logic cs_q;
        logic sclk_q;
        logic [2:0] bit_cnt;
        logic [6:0] shift_in;
        logic [7:0] shift_out;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic frame_start;
        logic oe;
    } rsar_shift_t;

    rsar_shift_t s;
    rsar_shift_t next_s;

    // Mode 0: sample on rising SCLK, update MISO on falling SCLK
    always_comb begin
        next_s = s;
        next_s.rx_valid = 1'b0;
        next_s.frame_start = 1'b0;
        next_s.cs_q = spi_cs_n;
        next_s.sclk_q = spi_sclk;
        next_s.oe = ~spi_cs_n;
        if (spi_cs_n) begin
            next_s.bit_cnt = 3'h0;
        end else if (s.cs_q) begin
            next_s.frame_start = 1'b1;
            next_s.shift_out = bus.tx_byte;
            next_s.bit_cnt = 3'h0;
        end else if (spi_sclk && !s.sclk_q) begin
            next_s.shift_in = {s.shift_in[5:0], spi_mosi};
            if (s.bit_cnt == 3'h7) begin
                next_s.rx_byte = {s.shift_in, spi_mosi};
                next_s.rx_valid = 1'b1;
            end
            next_s.bit_cnt = s.bit_cnt + 3'h1;
        end else if (!spi_sclk && s.sclk_q) begin
            if (s.bit_cnt == 3'h0) begin
                next_s.shift_out = bus.tx_byte;
            end else begin
                next_s.shift_out = {s.shift_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{cs_q: 1'b1, default: '0};
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign spi_miso = s.shift_out[7];
    assign spi_miso_oe = s.oe;
    assign bus.rx_byte = s.rx_byte;
    assign bus.rx_valid = s.rx_valid;
    assign bus.frame_start = s.frame_start;
endmodule

// [src/rsar_top.sv]
module rsar_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic rx_payload_stored,
    input wire logic tx_packet_sent,
    input wire logic ack_received,
    input wire logic auto_ack_enabled,
    input wire logic tx_packet_start,
    input wire logic tx_attempt_failed,
    input wire logic [2:0] rx_pipe_code,
    input wire logic tx_queue_full,
    input wire logic power_detect,
    input wire logic [1:0] address_width_setting,
    input wire logic [3:0] retransmit_limit_setting,
    output logic radio_halt,
    output logic rx_payload_ready_flag,
    output logic tx_done_flag,
    output logic retry_limit_flag,
    output logic [39:0] pipe0_address,
    output logic [39:0] pipe1_address,
    output logic [39:0] pipe2_address,
    output logic [39:0] pipe3_address
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        rsar_pkg::rsar_phase_t phase;
        logic [4:0] addr;
        logic is_read;
        logic is_write;
        logic [2:0] idx;
        logic rx_flag;
        logic done_flag;
        logic retry_flag;
        logic [2:0] pipe_code;
        logic tx_full;
        logic power;
        logic [39:0] p0;
        logic [39:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic halt;
        logic [39:0] eff0;
        logic [39:0] eff1;
        logic [39:0] eff2;
        logic [39:0] eff3;
    } rsar_state_t;

    rsar_state_t s;
    rsar_state_t next_s;

    rsar_spi_if spi ();

    logic [3:0] lost_count;
    logic [3:0] retransmit_count;
    logic retries_exhausted;
    logic lost_clear;
    logic gated_start;
    logic gated_fail;
    logic [2:0] byte_count;
    logic [4:0] byte_used;
    logic [39:0] width_mask;
    logic [7:0] status_byte;
    logic [7:0] observe_byte;
    logic [7:0] read_byte;
    logic wr_byte;

    // ----------------------------------------------------------------
    // Command port and counters
    // ----------------------------------------------------------------
    rsar_spi_shifter u_shifter (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .bus(spi.shifter)
    );

    // Radio activity is frozen while the retry limit flag stands
    assign gated_start = tx_packet_start & ~s.retry_flag;
    assign gated_fail = tx_attempt_failed & ~s.retry_flag;

    rsar_tx_counters #(
        .CNT_W(rsar_pkg::CNT_WIDTH)
    ) u_counters (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .tx_packet_start(gated_start),
        .tx_attempt_failed(gated_fail),
        .lost_clear(lost_clear),
        .retransmit_limit(retransmit_limit_setting),
        .lost_count(lost_count),
        .retransmit_count(retransmit_count),
        .retries_exhausted(retries_exhausted)
    );

    // ----------------------------------------------------------------
    // Address width
    // ----------------------------------------------------------------
    // Illegal code keeps all five bytes rather than losing address bits
    always_comb begin
        unique case (address_width_setting)
            rsar_pkg::AW_3: byte_count = 3'd3;
            rsar_pkg::AW_4: byte_count = 3'd4;
            rsar_pkg::AW_5: byte_count = 3'd5;
            rsar_pkg::AW_ILLEGAL: byte_count = 3'd5;
        endcase
    end

    genvar b;
    generate
        for (b = 0; b < rsar_pkg::ADDR_BYTES_MAX; b++) begin : g_byte
            assign byte_used[b] = (3'(b) < byte_count);
            assign width_mask[8*b +: 8] = {8{byte_used[b]}};
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[rsar_pkg::BIT_RX_READY] = s.rx_flag;
        status_byte[rsar_pkg::BIT_TX_DONE] = s.done_flag;
        status_byte[rsar_pkg::BIT_RETRY] = s.retry_flag;
        status_byte[rsar_pkg::PIPE_LSB +: 3] = s.pipe_code;
        status_byte[rsar_pkg::BIT_TX_FULL] = s.tx_full;
        observe_byte = 8'h00;
        observe_byte[rsar_pkg::LOST_LSB +: 4] = lost_count;
        observe_byte[rsar_pkg::RETX_LSB +: 4] = retransmit_count;
    end

    // Pipe bytes past the last one read back as zero; status, observe and power repeat on every byte
    always_comb begin
        read_byte = 8'h00;
        unique case (s.addr)
            rsar_pkg::ADDR_STATUS: read_byte = status_byte;
            rsar_pkg::ADDR_OBSERVE: read_byte = observe_byte;
            rsar_pkg::ADDR_POWER: read_byte = {7'h00, s.power};
            rsar_pkg::ADDR_PIPE0: begin
                if (s.idx < 3'd5) begin
                    read_byte = s.p0[{s.idx, 3'b000} +: 8];
                end
            end
            rsar_pkg::ADDR_PIPE1: begin
                if (s.idx < 3'd5) begin
                    read_byte = s.p1[{s.idx, 3'b000} +: 8];
                end
            end
            rsar_pkg::ADDR_PIPE2: begin
                if (s.idx == 3'd0) begin
                    read_byte = s.p2;
                end
            end
            rsar_pkg::ADDR_PIPE3: begin
                if (s.idx == 3'd0) begin
                    read_byte = s.p3;
                end
            end
            default: read_byte = 8'h00;
        endcase
    end

    // Status goes out on every frame's first byte
    assign spi.tx_byte = (s.phase == rsar_pkg::RSAR_DATA && s.is_read)
        ? read_byte : status_byte;

    // ----------------------------------------------------------------
    // Write strobes
    // ----------------------------------------------------------------
    assign wr_byte = spi.rx_valid && s.is_write &&
        (s.phase == rsar_pkg::RSAR_DATA);
    assign lost_clear = wr_byte && (s.addr == rsar_pkg::ADDR_CHANNEL);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic clr_rx;
        logic clr_done;
        logic clr_retry;
        logic set_done;
        clr_rx = 1'b0;
        clr_done = 1'b0;
        clr_retry = 1'b0;
        set_done = 1'b0;
        next_s = s;

        // Frame sequencing
        if (spi_cs_n) begin
            next_s.phase = rsar_pkg::RSAR_IDLE;
        end else begin
            unique case (s.phase)
                rsar_pkg::RSAR_IDLE: begin
                    next_s.phase = rsar_pkg::RSAR_CMD;
                end
                rsar_pkg::RSAR_CMD: begin
                    if (spi.rx_valid) begin
                        next_s.phase = rsar_pkg::RSAR_DATA;
                        next_s.addr = spi.rx_byte[4:0];
                        next_s.is_read =
                            (spi.rx_byte[7:5] == rsar_pkg::CMD_READ);
                        next_s.is_write =
                            (spi.rx_byte[7:5] == rsar_pkg::CMD_WRITE);
                        next_s.idx = 3'd0;
                    end
                end
                rsar_pkg::RSAR_DATA: begin
                    if (spi.rx_valid && s.idx != 3'd7) begin
                        next_s.idx = s.idx + 3'd1;
                    end
                end
            endcase
        end

        // Register writes, one byte at a time
        if (wr_byte) begin
            unique case (s.addr)
                rsar_pkg::ADDR_STATUS: begin
                    // Zeros and the read-only fields leave state alone
                    clr_rx = spi.rx_byte[rsar_pkg::BIT_RX_READY];
                    clr_done = spi.rx_byte[rsar_pkg::BIT_TX_DONE];
                    clr_retry = spi.rx_byte[rsar_pkg::BIT_RETRY];
                end
                rsar_pkg::ADDR_PIPE0: begin
                    // Bytes beyond the set width are dropped
                    if (s.idx < byte_count) begin
                        next_s.p0[{s.idx, 3'b000} +: 8] = spi.rx_byte;
                    end
                end
                rsar_pkg::ADDR_PIPE1: begin
                    if (s.idx < byte_count) begin
                        next_s.p1[{s.idx, 3'b000} +: 8] = spi.rx_byte;
                    end
                end
                rsar_pkg::ADDR_PIPE2: begin
                    if (s.idx == 3'd0) begin
                        next_s.p2 = spi.rx_byte;
                    end
                end
                rsar_pkg::ADDR_PIPE3: begin
                    if (s.idx == 3'd0) begin
                        next_s.p3 = spi.rx_byte;
                    end
                end
                default: begin
                end
            endcase
        end

        // Interrupt flags: a set in the same cycle beats the clear
        set_done = auto_ack_enabled ? ack_received
            : tx_packet_sent;
        next_s.rx_flag = (s.rx_flag & ~clr_rx) | rx_payload_stored;
        next_s.done_flag = (s.done_flag & ~clr_done) | set_done;
        next_s.retry_flag = (s.retry_flag & ~clr_retry) |
            retries_exhausted;
        next_s.halt = next_s.retry_flag;

        // Read-only observation
        next_s.pipe_code = rx_pipe_code;
        next_s.tx_full = tx_queue_full;
        next_s.power = power_detect;

        // Addresses as the receiver sees them, unused upper bytes zero
        next_s.eff0 = next_s.p0 & width_mask;
        next_s.eff1 = next_s.p1 & width_mask;
        next_s.eff2 = {next_s.p1[39:8], next_s.p2} & width_mask;
        next_s.eff3 = {next_s.p1[39:8], next_s.p3} & width_mask;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{
                phase: rsar_pkg::RSAR_IDLE,
                pipe_code: rsar_pkg::PIPE_EMPTY,
                p0: rsar_pkg::PIPE0_RESET,
                p1: rsar_pkg::PIPE1_RESET,
                p2: rsar_pkg::PIPE2_RESET,
                p3: rsar_pkg::PIPE3_RESET,
                eff0: rsar_pkg::PIPE0_RESET,
                eff1: rsar_pkg::PIPE1_RESET,
                eff2: {rsar_pkg::PIPE1_RESET[39:8], rsar_pkg::PIPE2_RESET},
                eff3: {rsar_pkg::PIPE1_RESET[39:8], rsar_pkg::PIPE3_RESET},
                default: '0
            };
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign radio_halt = s.halt;
    assign rx_payload_ready_flag = s.rx_flag;
    assign tx_done_flag = s.done_flag;
    assign retry_limit_flag = s.retry_flag;
    assign pipe0_address = s.eff0;
    assign pipe1_address = s.eff1;
    assign pipe2_address = s.eff2;
    assign pipe3_address = s.eff3;
endmodule

// [src/rsar_tx_counters.sv]
module rsar_tx_counters #(
    parameter int CNT_W = rsar_pkg::CNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic tx_packet_start,
    input wire logic tx_attempt_failed,
    input wire logic lost_clear,
    input wire logic [CNT_W-1:0] retransmit_limit,
    output logic [CNT_W-1:0] lost_count,
    output logic [CNT_W-1:0] retransmit_count,
    output logic retries_exhausted
);
    generate
        if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
            $error("rsar_tx_counters: CNT_W must be 1 to 8");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] lost;
        logic [CNT_W-1:0] retx;
        logic exhausted;
    } rsar_cnt_t;

    rsar_cnt_t s;
    rsar_cnt_t next_s;

    always_comb begin
        next_s = s;
        next_s.exhausted = 1'b0;
        if (lost_clear) begin
            next_s.lost = '0;
        end
        if (tx_packet_start) begin
            next_s.retx = '0;
        end else if (tx_attempt_failed) begin
            if (s.retx >= retransmit_limit) begin
                next_s.exhausted = 1'b1;
                // Holds at all ones until cleared
                if (next_s.lost != '1) begin
                    next_s.lost = next_s.lost + 1'b1;
                end
            end else begin
                next_s.retx = s.retx + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign lost_count = s.lost;
    assign retransmit_count = s.retx;
    assign retries_exhausted = s.exhausted;
endmodule

// [tb/rsar_host.sv]
module rsar_host (
    input wire logic ref_clk,
    input wire logic spi_miso,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic done,
    output logic [7:0] stat_seen,
    output logic [39:0] data_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {spi_cs_n, spi_sclk, spi_mosi, done} = 4'ha;
        stat_seen = 8'h0;
        data_seen = 40'h0;
    end

    // ----
    // Mode 0 frames, four ref_clk cycles per clock phase
    // ----
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi <= tx[i];
            repeat (4) @(posedge ref_clk);
            rx[i] = spi_miso;
            spi_sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            spi_sclk <= 1'b0;
        end
    endtask

    task automatic frame(input logic [7:0] cmd, input int n,
                         input logic [39:0] wd);
        logic [7:0] st;
        logic [7:0] b;
        logic [39:0] rd;
        rd = 40'h0;
        @(posedge ref_clk);
        spi_cs_n <= 1'b0;
        shift(cmd, st);
        for (int k = 0; k < n; k++) begin
            shift(wd[8*k +: 8], b);
            rd[8*k +: 8] = b;
        end
        repeat (4) @(posedge ref_clk);
        spi_cs_n <= 1'b1;
        // Released data line must not keep its last level
        spi_mosi <= ~spi_mosi;
        stat_seen <= st;
        data_seen <= rd;
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

// [tb/rsar_top_chk.sv]
module rsar_top_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic rx_payload_stored,
    input wire logic tx_packet_sent,
    input wire logic ack_received,
    input wire logic auto_ack_enabled,
    input wire logic tx_attempt_failed,
    input wire logic radio_halt,
    input wire logic rx_payload_ready_flag,
    input wire logic tx_done_flag,
    input wire logic retry_limit_flag,
    input wire logic [39:0] pipe1_address,
    input wire logic [39:0] pipe2_address,
    input wire logic [39:0] pipe3_address
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ----
    // Frame and flag behaviour
    // ----
    sequence frame_open;
        $fell(spi_cs_n);
    endsequence
    sequence status_msb;
        spi_miso_oe && !spi_miso;
    endsequence
    sequence any_flag_fell;
        $fell(rx_payload_ready_flag) || $fell(tx_done_flag) ||
            $fell(retry_limit_flag);
    endsequence

    status_first_a: assert property (frame_open |-> ##[1:2] status_msb)
        else $error("no status msb");
    rx_flag_set_a: assert property (rx_payload_stored && clk_en |=> rx_payload_ready_flag)
        else $error("rx flag unset");
    tx_done_set_a: assert property (tx_packet_sent && clk_en && !auto_ack_enabled |=> tx_done_flag)
        else $error("done unset");
    tx_done_cause_a: assert property ($rose(tx_done_flag) |-> ($past(auto_ack_enabled) ? $past(ack_received) : $past(tx_packet_sent)))
        else $error("done no cause");
    flag_clear_cause_a: assert property (any_flag_fell |-> !$past(spi_cs_n))
        else $error("clear no frame");
    halt_follows_a: assert property (radio_halt == retry_limit_flag)
        else $error("halt mismatch");
    retry_cause_a: assert property ($rose(retry_limit_flag) |-> ($past(tx_attempt_failed, 2) || $past(tx_attempt_failed)))
        else $error("retry no cause");
    pipe2_upper_a: assert property (pipe2_address[39:8] == pipe1_address[39:8])
        else $error("pipe2 upper");
    pipe3_upper_a: assert property (pipe3_address[39:8] == pipe1_address[39:8])
        else $error("pipe3 upper");
endmodule

// [tb/rsar_top_test.sv]
module rsar_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] st;
        logic [39:0] dt;
        logic [39:0] msk;
        logic [39:0] p0;
    } rsar_note_t;
    logic ref_clk, arst_n, clk_en, spi_cs_n, spi_sclk, spi_mosi;
    logic spi_miso, spi_miso_oe, miso_line, done;
    logic auto_ack_enabled;
    logic [4:0] ev;
    logic [2:0] rx_pipe_code;
    logic tx_queue_full, power_detect, radio_halt;
    logic [1:0] address_width_setting;
    logic [3:0] retransmit_limit_setting;
    logic rx_payload_ready_flag, tx_done_flag, retry_limit_flag;
    logic [39:0] pipe0_address, pipe1_address, pipe2_address;
    logic [39:0] pipe3_address, data_seen, p0m, v;
    logic [7:0] stat_seen, rnd;
    logic f_rx, f_tx, f_rt;
    logic [3:0] lim;
    rsar_note_t notes[$];
    rsar_note_t nt;
    int err_total = 0;
    int samples_checked = 0;

    // Undriven miso must not look like valid data
    assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

    rsar_top u_rsar_top (
        .ref_clk, .arst_n, .clk_en, .spi_cs_n, .spi_sclk, .spi_mosi,
        .spi_miso, .spi_miso_oe, .rx_payload_stored(ev[0]),
        .tx_packet_sent(ev[1]), .ack_received(ev[2]), .auto_ack_enabled,
        .tx_packet_start(ev[3]), .tx_attempt_failed(ev[4]),
        .rx_pipe_code, .tx_queue_full, .power_detect,
        .address_width_setting, .retransmit_limit_setting, .radio_halt,
        .rx_payload_ready_flag, .tx_done_flag, .retry_limit_flag,
        .pipe0_address, .pipe1_address, .pipe2_address, .pipe3_address
    );
    rsar_host u_rsar_host (
        .ref_clk, .spi_miso(miso_line), .spi_cs_n, .spi_sclk, .spi_mosi,
        .done, .stat_seen, .data_seen
    );

    // ----
    // Helpers
    // ----
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] stat();
        return {1'b0, f_rx, f_tx, f_rt, rx_pipe_code, tx_queue_full};
    endfunction
    task automatic cmp8(string what, logic [7:0] e, logic [7:0] s);
        cmp40(what, {32'h0, e}, {32'h0, s});
    endtask
    task automatic cmp40(string what, logic [39:0] e, logic [39:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic op(logic [7:0] cmd, int n, logic [39:0] wd,
                      logic [39:0] ex);
        notes.push_back('{stat(), ex,
            cmd[5] ? 40'h0 : {40{1'b1}} >> (40 - 8 * n), p0m});
        u_rsar_host.frame(cmd, n, wd);
    endtask
    // Event k: stored, sent, ack, start, failed
    task automatic pulse(int k);
        ev <= 5'h1 << k;
        @(posedge ref_clk);
        ev <= 5'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                err_total++;
                $display("FAIL notes expected 1 seen 0");
            end else begin
                nt = notes.pop_front();
                cmp8("status", nt.st, stat_seen);
                cmp40("data", nt.dt & nt.msk, data_seen & nt.msk);
                cmp40("pipe0", nt.p0, pipe0_address);
            end
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        {arst_n, ev, auto_ack_enabled} = 7'h0;
        {tx_queue_full, power_detect, f_rx, f_tx, f_rt} = 5'h0;
        clk_en = 1'b1;
        rx_pipe_code = 3'h7;
        address_width_setting = 2'h3;
        retransmit_limit_setting = 4'h3;
        rnd = 8'h5e;
        p0m = 40'he7e7e7e7e7;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        op(8'h07, 1, 40'h0, 40'h0e);
        op(8'h08, 1, 40'h0, 40'h0);
        op(8'h09, 1, 40'h0, 40'h0);
        op(8'h0a, 5, 40'h0, 40'he7e7e7e7e7);
        op(8'h0b, 5, 40'h0, 40'hc2c2c2c2c2);
        op(8'h0c, 1, 40'h0, 40'hc3);
        op(8'h0d, 1, 40'h0, 40'hc4);
        $display("test reset done");
        rnd = lfsr(rnd);
        rx_pipe_code <= 3'(rnd % 6);
        {power_detect, tx_queue_full} <= 2'h3;
        pulse(0);
        pulse(1);
        {f_rx, f_tx} = 2'h3;
        op(8'h09, 1, 40'h0, 40'h01);
        op(8'h07, 1, 40'h0, {32'h0, stat()});
        op(8'h27, 1, 40'h21, 40'h0);
        f_tx = 1'b0;
        auto_ack_enabled <= 1'b1;
        pulse(1);
        op(8'h07, 1, 40'h0, {32'h0, stat()});
        pulse(2);
        f_tx = 1'b1;
        op(8'h27, 1, 40'h60, 40'h0);
        {f_rx, f_tx} = 2'h0;
        $display("test flags done");
        rnd = lfsr(rnd);
        lim = {2'h0, rnd[1:0]};
        retransmit_limit_setting <= lim;
        pulse(3);
        for (int i = 0; i < lim; i++) pulse(4);
        op(8'h08, 1, 40'h0, {32'h0, 4'h0, lim});
        pulse(4);
        f_rt = 1'b1;
        pulse(3);
        op(8'h08, 1, 40'h0, {32'h0, 4'h1, lim});
        op(8'h27, 1, 40'h10, 40'h0);
        f_rt = 1'b0;
        pulse(3);
        op(8'h08, 1, 40'h0, 40'h10);
        retransmit_limit_setting <= 4'h0;
        repeat (15) begin
            pulse(3);
            pulse(4);
            f_rt = 1'b1;
            op(8'h27, 1, 40'h10, 40'h0);
            f_rt = 1'b0;
        end
        op(8'h08, 1, 40'h0, 40'hf0);
        op(8'h25, 1, 40'h11, 40'h0);
        op(8'h08, 1, 40'h0, 40'h0);
        $display("test counters done");
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            v[8*i +: 8] = rnd;
        end
        p0m = v;
        op(8'h2a, 5, v, 40'h0);
        op(8'h0a, 5, 40'h0, v);
        op(8'h2b, 5, ~v, 40'h0);
        op(8'h2c, 1, v, 40'h0);
        op(8'h0b, 5, 40'h0, ~v);
        op(8'h0c, 1, 40'h0, {32'h0, v[7:0]});
        for (int w = 1; w <= 3; w++) begin
            address_width_setting <= 2'(w);
            p0m = v & ({40{1'b1}} >> (8 * (3 - w)));
            op(8'h07, 1, 40'h0, {32'h0, stat()});
        end
        $display("test addresses done");
        repeat (8) @(posedge ref_clk);
        if (notes.size() != 0)
            err_total++;
        finish_test();
    end
endmodule

bind rsar_top rsar_top_chk u_rsar_top_chk (
    .ref_clk, .arst_n, .clk_en, .spi_cs_n, .spi_miso, .spi_miso_oe,
    .rx_payload_stored, .tx_packet_sent, .ack_received,
    .auto_ack_enabled, .tx_attempt_failed, .radio_halt,
    .rx_payload_ready_flag, .tx_done_flag, .retry_limit_flag,
    .pipe1_address, .pipe2_address, .pipe3_address
);
